/* File: hw/sfl_core.sv */
// serial port core: registers, master sequencer, slave control, faults.
// assumes a one-cycle read or write strobe from the cpu side and an
// outside pad that resolves each pin from its output enable.
`timescale 1ns/100ps
`default_nettype none
`include "sfl_params.svh"

// How it works
// (R01) idle level and phase pick four formats
// (R02) phase 0: msb out before first edge
// (R03) phase 0 master toggles select per byte
// (R04) phase 1: first edge starts the transfer
// (R05) phase 1 select may stay low; the core loads the next slave byte only while select is high
// (R06) slave drives data only while selected
// (R07) data write starts master, phase shapes clock
// (R08) bit clock runs only enabled as master
// (R09) start delay at most one bit time
// (R10) clock edges placed inside bus cycle
// (R11) unread byte at bit one: overrun, discard
// (R12) one error enable gates overrun and fault
// (R13) receive, fault, overrun share one request
// (R14) fault flag sets only while enabled
// (R15) master select low: fault, disable, abort
// (R16) fault keeps the master select bit
// (R17) slave select rising mid transfer faults
// (R18) phase 0 select alone begins transfer
// (R19) slave fault keeps module enabled
// (R20) deselected slave floats data, ignores clock
// (R21) fault clears on status read, control write
// (R22) disable before changing clock format
// (R23) receive flag clears status then data read
// (R24) disabled: empty, abort, clear, release pins
// (R25) rate code picks divide 2,8,32,128
// (R26) eight bits msb first, full duplex
module sfl_core #(
    parameter int unsigned DIV0 = `SFL_BIT_DIVIDE_BY_TWO,
    parameter int unsigned DIV1 = `SFL_BIT_DIVIDE_BY_EIGHT,
    parameter int unsigned DIVIDE_BY_TWO = `SFL_BIT_DIVIDE_BY_THIRTYTWO,
    parameter int unsigned DIV3 = `SFL_BIT_DIVIDE_BY_ONETWENTYEIGHT
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire sfl_pkg::sfl_byte_t reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic irq_rx_err,
    output logic irq_tx
);
    import sfl_pkg::*;

    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    if (DIV0 < 2 || DIV1 < 2 || DIVIDE_BY_TWO < 2 || DIV3 < 2 ||
        DIV0 > `SFL_BIT_MAX || DIV1 > `SFL_BIT_MAX ||
        DIVIDE_BY_TWO > `SFL_BIT_MAX || DIV3 > `SFL_BIT_MAX ||
        DIV0 % 2 != 0 || DIV1 % 2 != 0 || DIVIDE_BY_TWO % 2 != 0 || DIV3 % 2 != 0) begin : g_chk
        $error("bit times must be even and from 2 to 128 cycles");
    end

    sfl_core_s r;
    sfl_core_s n;
    sfl_link_if lk ();

    logic en;
    logic master_sel_bit;
    logic clock_phase_sel;
    logic tick;
    logic [6:0] half_tc;
    logic m_first;
    logic m_done;
    logic s_start;
    logic s_done;
    logic first_ev;
    logic done_ev;
    sfl_byte_t done_byte;
    logic m_fault;
    logic s_fault;
    logic fault_now;

    // ----------------------------------------
    // slave link in the serial clock domain
    // ----------------------------------------
    // (R01) capture edge from idle level and phase
    // xor folds the four formats onto one rising capture clock
    assign lk.sample_clk = sck_in ^ r.ctrl[`SFL_C_CLOCK_IDLE_LEVEL_SEL] ^ r.ctrl[`SFL_C_CLOCK_PHASE_SEL];
    assign lk.clr = ss_n_in | ~r.slv_en;
    assign lk.mosi = mosi_in;
    assign lk.tx_hold = r.slv_tx;

    sfl_slave_link u_link (
        .rst (rst),
        .lk (lk.link)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = r;
        en = r.ctrl[`SFL_C_EN];
        master_sel_bit = r.ctrl[`SFL_C_MASTER_SEL_BIT];
        clock_phase_sel = r.ctrl[`SFL_C_CLOCK_PHASE_SEL];

        // pin and event synchronisers
        n.ss_s1 = ss_n_in;
        n.ss_s2 = r.ss_s1;
        n.ss_d = r.ss_s2;
        n.miso_s1 = miso_in;
        n.miso_s2 = r.miso_s1;
        n.stg = {r.stg[1:0], lk.start_tg};
        n.dtg = {r.dtg[1:0], lk.done_tg};
        s_start = en & ~master_sel_bit & (r.stg[2] ^ r.stg[1]);
        s_done = en & ~master_sel_bit & (r.dtg[2] ^ r.dtg[1]);

        // (R25) rate code to half bit count
        case (r.rate)
            2'b00: half_tc = 7'(DIV0 / 2 - 1);
            2'b01: half_tc = 7'(DIV1 / 2 - 1);
            2'b10: half_tc = 7'(DIVIDE_BY_TWO / 2 - 1);
            default: half_tc = 7'(DIV3 / 2 - 1);
        endcase

        // (R08) free running only as enabled master
        tick = 1'b0;
        if (en && master_sel_bit) begin
            tick = (r.div >= half_tc);
            n.div = tick ? 7'd0 : r.div + 7'd1;
        end else begin
            n.div = 7'd0;
        end

        // master sequencer, one half bit per tick
        m_first = 1'b0;
        m_done = 1'b0;
        case (r.st)
            mst_idle: begin
                // (R09) waits at most one half-bit tick
                if (tick && r.tx_full) begin
                    n.st = mst_run;
                    n.ph = 4'd0;
                    n.sh = r.tx_buf;
                    n.tx_full = 1'b0;
                    n.te = 1'b1;
                end
            end
            mst_run: begin
                if (tick) begin
                    n.ph = r.ph + 4'd1;
                    if (!r.ph[0]) begin
                        n.cap = r.miso_s2;
                        m_first = (r.ph == 4'd0);
                    end else if (r.ph == 4'hf) begin
                        m_done = 1'b1;
                        n.st = mst_idle;
                    end else begin
                        // (R26) shift msb first
                        n.sh = {r.sh[6:0], r.cap};
                    end
                end
            end
            default: n.st = mst_idle;
        endcase

        // (R18) phase 0: falling select begins the slave transfer
        if (en && !master_sel_bit && !clock_phase_sel && !r.ss_s2 && r.ss_d) begin
            n.slv_run = 1'b1;
        end
        // (R04) phase 1: first edge begins the slave transfer
        if (s_start) begin
            n.slv_run = 1'b1;
        end
        if (s_done) begin
            n.slv_run = 1'b0;
        end

        // slave loads its next byte only between transfers
        if (en && !master_sel_bit && r.tx_full && !r.slv_run && r.ss_s2) begin
            n.slv_tx = r.tx_buf;
            n.tx_full = 1'b0;
            n.te = 1'b1;
        end

        // faults seen on the synchronised select
        m_fault = en & master_sel_bit & ~r.ss_s2;
        // (R17) select rising during a slave transfer
        s_fault = en & ~master_sel_bit & r.ss_s2 & ~r.ss_d & r.slv_run;
        fault_now = m_fault | s_fault;
        if (s_fault) begin
            n.slv_run = 1'b0;
        end

        // register reads, with the first step of each flag clear
        n.rd_data = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `SFL_OFS_CTRL: n.rd_data = r.ctrl;
                `SFL_OFS_STAT: begin
                    n.rd_data = {r.rf, r.error_irq_enable, r.ovr, r.select_fault_flag, r.te, r.select_fault_enable, r.rate};
                    n.rf_arm = r.rf;
                    n.ovr_arm = r.ovr;
                    n.select_fault_flag_arm = r.select_fault_flag;
                end
                `SFL_OFS_DATA: begin
                    n.rd_data = r.rx_data;
                    // (R23) status then data read
                    if (r.rf_arm) begin
                        n.rf = 1'b0;
                    end
                    if (r.ovr_arm) begin
                        n.ovr = 1'b0;
                    end
                    n.rf_arm = 1'b0;
                    n.ovr_arm = 1'b0;
                end
                default: n.rd_data = 8'h00;
            endcase
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `SFL_OFS_CTRL: begin
                    // (R22) format bits take effect at once
                    n.ctrl = reg_wdata & `SFL_CTRL_WMASK;
                    // (R21) status read then control write
                    if (r.select_fault_flag_arm && !fault_now) begin
                        n.select_fault_flag = 1'b0;
                    end
                    n.select_fault_flag_arm = 1'b0;
                end
                `SFL_OFS_STAT: begin
                    n.error_irq_enable = reg_wdata[`SFL_S_ERROR_IRQ_ENABLE];
                    n.select_fault_enable = reg_wdata[`SFL_S_SELECT_FAULT_ENABLE];
                    n.rate = reg_wdata[`SFL_S_RATE_HI:`SFL_S_RATE_LO];
                end
                `SFL_OFS_DATA: begin
                    // (R07) a data write queues the next transfer
                    n.tx_buf = reg_wdata;
                    n.tx_full = 1'b1;
                    n.te = 1'b0;
                end
                default: n.tx_full = n.tx_full;
            endcase
        end

        // (R21) any fault during the sequence spoils the clear
        if (fault_now) begin
            n.select_fault_flag_arm = 1'b0;
        end

        // (R11) overrun judged at the first capture
        first_ev = m_first | s_start;
        done_ev = m_done | s_done;
        done_byte = master_sel_bit ? {r.sh[6:0], r.cap} : lk.rx_byte;
        if (first_ev) begin
            n.discard = n.rf;
            if (n.rf) begin
                n.ovr = 1'b1;
            end
        end
        // discarded bytes leave the unread one in place
        if (done_ev && !r.discard) begin
            n.rx_data = done_byte;
            n.rf = 1'b1;
        end

        // (R14) fault flag gated by its enable
        if (r.select_fault_enable && fault_now) begin
            n.select_fault_flag = 1'b1;
        end
        // (R15) master fault drops enable
        // (R16) master select bit left as it was
        if (r.select_fault_enable && m_fault) begin
            n.ctrl[`SFL_C_EN] = 1'b0;
        end
        // (R19) slave fault leaves enable alone

        // (R24) disabled: abort and clear shift state
        if (!n.ctrl[`SFL_C_EN]) begin
            n.te = 1'b1;
            n.tx_full = 1'b0;
            n.st = mst_idle;
            n.ph = 4'd0;
            n.sh = 8'h00;
            n.cap = 1'b0;
            n.slv_run = 1'b0;
            n.discard = 1'b0;
        end
        n.slv_en = n.ctrl[`SFL_C_EN] & ~n.ctrl[`SFL_C_MASTER_SEL_BIT];

        // pins, registered; pads fall back to port use when disabled
        // (R10) edges land on a bus clock edge, the nearest synchronous point
        // (R07) phase 0 idles first half, phase 1 leads with an edge
        n.sck_o = n.ctrl[`SFL_C_CLOCK_IDLE_LEVEL_SEL] ^ ((n.st == mst_run) &
            (n.ctrl[`SFL_C_CLOCK_PHASE_SEL] ? ~n.ph[0] : n.ph[0]));
        n.sck_oe = n.ctrl[`SFL_C_EN] & n.ctrl[`SFL_C_MASTER_SEL_BIT];
        n.mosi_o = n.sh[7];
        // open drain option drives only low levels on mosi; sck and miso are driven both ways
        n.mosi_oe = n.sck_oe & (~n.ctrl[`SFL_C_WOM] | ~n.sh[7]);
        // (R06) slave drives data only while selected
        n.miso_oe = n.slv_en & ~r.ss_s2;

        // (R12) one enable for overrun and fault
        // (R13) all three share one request
        n.irq_rx = (n.rf & n.ctrl[`SFL_C_RIE] & n.ctrl[`SFL_C_EN]) |
            (n.error_irq_enable & (n.ovr | n.select_fault_flag));
        n.irq_tx = n.te & n.ctrl[`SFL_C_TIE];
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // select synchroniser resets high so reset never looks like a fault
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
            r.ctrl <= `SFL_CTRL_RST;
            r.te <= 1'(`SFL_STAT_RST >> `SFL_S_TE);
            r.ss_s1 <= 1'b1;
            r.ss_s2 <= 1'b1;
            r.ss_d <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rd_data;
    assign sck_out = r.sck_o;
    assign sck_oe = r.sck_oe;
    assign mosi_out = r.mosi_o;
    assign mosi_oe = r.mosi_oe;
    assign miso_out = lk.miso;
    assign miso_oe = r.miso_oe;
    assign irq_rx_err = r.irq_rx;
    assign irq_tx = r.irq_tx;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_te_when_off: assert property (!r.ctrl[`SFL_C_EN] |=> r.te) // (R24)
        else $error("transmit empty not set while disabled");
    a_mfault_drop: assert property (r.select_fault_enable && m_fault |=> !r.ctrl[`SFL_C_EN] && r.select_fault_flag) // (R15)
        else $error("master fault did not disable and flag");
    a_master_sel_bit_kept: assert property ($rose(r.select_fault_flag) |-> $stable(r.ctrl[`SFL_C_MASTER_SEL_BIT])) // (R16)
        else $error("fault changed the master select bit");
    a_start_delay: assert property (reg_wr && reg_addr == `SFL_OFS_DATA // (R09)
        && r.st == mst_idle && en && master_sel_bit |-> ##[1:130] (r.st == mst_run || !r.ctrl[`SFL_C_EN]))
        else $error("master start later than one bit time");
    a_ovr_discard: assert property (first_ev && r.rf && !reg_rd && !reg_wr && !m_fault // (R11)
        |=> r.ovr ##0 r.discard)
        else $error("overrun not flagged on unread byte");
    a_fault_gate: assert property (!r.select_fault_enable && !r.select_fault_flag |=> !r.select_fault_flag) // (R14)
        else $error("fault flag set while disabled");
    a_phase0_idle: assert property ($rose(r.st == mst_run) && !clock_phase_sel // (R07)
        |-> r.sck_o == r.ctrl[`SFL_C_CLOCK_IDLE_LEVEL_SEL])
        else $error("phase 0 clock left idle too early");
    a_div_stop: assert property (!(en && master_sel_bit) |=> r.div == 7'd0) // (R08)
        else $error("bit clock ran outside enabled master");
    a_slave_keep: assert property (s_fault && !reg_wr |=> r.ctrl[`SFL_C_EN]) // (R19)
        else $error("slave fault cleared the enable");
    a_err_irq: assert property (r.error_irq_enable && r.ovr && !reg_wr |=> irq_rx_err || !r.ovr) // (R12)
        else $error("overrun did not raise the shared request");
    a_miso_float: assert property (r.ss_s2 |=> !r.miso_oe) // (R20)
        else $error("data out driven while deselected");

endmodule

`default_nettype wire

/* File: inc/sfl_params.svh */
// constants of the serial port: register offsets, field positions,
// reset values and bit times.
// assumes an 8-bit register port addressed at the printed offsets.
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SFL_OFS_CTRL 8'h10
`define SFL_OFS_STAT 8'h11
`define SFL_OFS_DATA 8'h12

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SFL_C_RIE 7
`define SFL_C_MASTER_SEL_BIT 5
`define SFL_C_CLOCK_IDLE_LEVEL_SEL 4
`define SFL_C_CLOCK_PHASE_SEL 3
`define SFL_C_WOM 2
`define SFL_C_EN 1
`define SFL_C_TIE 0
`define SFL_CTRL_WMASK 8'hbf

// ----------------------------------------
// status register fields
// ----------------------------------------
`define SFL_S_RF 7
`define SFL_S_ERROR_IRQ_ENABLE 6
`define SFL_S_OVR 5
`define SFL_S_SELECT_FAULT_FLAG 4
`define SFL_S_TE 3
`define SFL_S_SELECT_FAULT_ENABLE 2
`define SFL_S_RATE_HI 1
`define SFL_S_RATE_LO 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SFL_CTRL_RST 8'h28
`define SFL_STAT_RST 8'h08

// ----------------------------------------
// bit times in bus cycles, one per rate code
// ----------------------------------------
`define SFL_BIT_DIVIDE_BY_TWO 2
`define SFL_BIT_DIVIDE_BY_EIGHT 8
`define SFL_BIT_DIVIDE_BY_THIRTYTWO 32
`define SFL_BIT_DIVIDE_BY_ONETWENTYEIGHT 128
`define SFL_BIT_MAX 128

`endif

/* File: inc/sfl_pkg.sv */
// types shared by the serial port core and its slave link.
// assumes nothing beyond a SystemVerilog compiler.
package sfl_pkg;

    typedef logic [7:0] sfl_byte_t;

    // master sequencer, gray along idle -> run
    typedef enum logic [0:0] {
        mst_idle = 1'b0,
        mst_run = 1'b1
    } sfl_mst_e;

    // bus-clock state of the core
    typedef struct packed {
        sfl_byte_t ctrl;
        logic error_irq_enable;
        logic select_fault_enable;
        logic [1:0] rate;
        logic rf;
        logic ovr;
        logic select_fault_flag;
        logic te;
        sfl_byte_t tx_buf;
        logic tx_full;
        sfl_byte_t rx_data;
        sfl_byte_t sh;
        logic cap;
        logic [3:0] ph;
        logic [6:0] div;
        sfl_mst_e st;
        logic discard;
        logic ss_s1;
        logic ss_s2;
        logic ss_d;
        logic miso_s1;
        logic miso_s2;
        logic [2:0] stg;
        logic [2:0] dtg;
        sfl_byte_t slv_tx;
        logic slv_run;
        logic slv_en;
        logic rf_arm;
        logic ovr_arm;
        logic select_fault_flag_arm;
        sfl_byte_t rd_data;
        logic irq_rx;
        logic irq_tx;
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_oe;
    } sfl_core_s;

    // link-clock shifter, cleared while deselected
    typedef struct packed {
        logic [2:0] cnt;
        sfl_byte_t sh;
    } sfl_shift_s;

    // link-clock event toggles and received byte
    typedef struct packed {
        logic start_tg;
        logic done_tg;
        sfl_byte_t rx;
    } sfl_tog_s;

endpackage

/* File: inc/sfl_link_if.sv */
// signals between the bus-clock core and the slave shifter.
// assumes sfl_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none

interface sfl_link_if;
    import sfl_pkg::*;
    logic sample_clk;
    logic clr;
    logic mosi;
    sfl_byte_t tx_hold;
    logic miso;
    logic start_tg;
    logic done_tg;
    sfl_byte_t rx_byte;

    modport core (
        output sample_clk, output clr, output mosi, output tx_hold,
        input miso, input start_tg, input done_tg, input rx_byte
    );
    modport link (
        input sample_clk, input clr, input mosi, input tx_hold,
        output miso, output start_tg, output done_tg, output rx_byte
    );
endinterface

`default_nettype wire

/* File: hw/sfl_slave_link.sv */
// slave shifter running on the incoming serial clock.
// assumes sample_clk rises on every capture edge and tx_hold is
// stable while the slave is selected.
`timescale 1ns/100ps
`default_nettype none

module sfl_slave_link (
    input wire logic rst,
    sfl_link_if.link lk
);
    import sfl_pkg::*;

    sfl_shift_s sh_r;
    sfl_shift_s sh_nxt;
    sfl_tog_s tg_r;
    sfl_tog_s tg_nxt;
    logic first;
    logic last;
    sfl_byte_t src;

    // ----------------------------------------
    // shift and event logic
    // ----------------------------------------
    // first capture uses the held byte, so msb is out before any edge
    always_comb begin
        first = (sh_r.cnt == 3'd0);
        last = (sh_r.cnt == 3'd7);
        src = first ? lk.tx_hold : sh_r.sh;
        // (R26) msb first full duplex
        sh_nxt.cnt = sh_r.cnt + 3'd1;
        sh_nxt.sh = {src[6:0], lk.mosi};
        tg_nxt = tg_r;
        // (R20) no events while deselected
        if (first && !lk.clr) begin
            tg_nxt.start_tg = ~tg_r.start_tg;
        end
        if (last) begin
            tg_nxt.done_tg = ~tg_r.done_tg;
            tg_nxt.rx = {sh_r.sh[6:0], lk.mosi};
        end
    end

    // (R20) deselect clears shifter
    // clr is held while select is high, so every edge is ignored
    always_ff @(posedge lk.sample_clk or posedge lk.clr) begin
        if (lk.clr) begin
            sh_r <= '0;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    // toggles survive deselect so the core never sees a false event
    always_ff @(posedge lk.sample_clk or posedge rst) begin
        if (rst) begin
            tg_r <= '0;
        end else begin
            tg_r <= tg_nxt;
        end
    end

    // (R02) msb ready before first edge
    assign lk.miso = src[7];
    assign lk.start_tg = tg_r.start_tg;
    assign lk.done_tg = tg_r.done_tg;
    assign lk.rx_byte = tg_r.rx;

endmodule

`default_nettype wire

/* File: test/sfl_peer.sv */
// far-side model: slave to the core as master, master to the core as slave.
// assumes the bench resolves the shared pins and holds the format steady.
`timescale 1ns/100ps
`default_nettype none

module sfl_peer (
    input wire logic sck_pin,
    input wire logic mosi_pin,
    input wire logic miso_pin,
    input wire logic clock_idle_level_sel,
    input wire logic clock_phase_sel,
    output logic miso_drv,
    output logic sck_drv,
    output logic mosi_drv,
    output logic ss_n_drv
);
    logic [7:0] s_tx;
    logic [7:0] s_rx;
    int s_cnt;

    initial begin
        sck_drv = 1'b0;
        mosi_drv = 1'b0;
        ss_n_drv = 1'b1;
        s_tx = 8'h00;
        s_cnt = 0;
    end

    // slave shifter per format
    // no shift on a launch edge before the first capture, so phase 1 keeps the msb
    always @(sck_pin) begin
        if (sck_pin === ~(clock_idle_level_sel ^ clock_phase_sel)) begin
            s_rx = {s_rx[6:0], mosi_pin};
            s_cnt++;
        end else if (s_cnt != 0) begin
            s_tx = {s_tx[6:0], ~s_tx[0]};
        end
    end
    assign miso_drv = s_tx[7];

    task load(input logic [7:0] b);
        s_tx = b;
        s_cnt = 0;
    endtask

    // clock bursts with select high, which a slave must ignore
    task automatic idle_clk();
        repeat (8) begin
            #24 sck_drv = 1'b1;
            #24 sck_drv = 1'b0;
        end
    endtask

    // master frame, select per byte
    // clock stands still outside the frame; phase 0, idle low only
    task automatic mxfer(input logic [7:0] tx, output logic [7:0] rx);
        ss_n_drv = 1'b0;
        #100;
        for (int i = 7; i >= 0; i--) begin
            mosi_drv = tx[i];
            // sample before the capture edge; the slave may update on it
            #24 rx[i] = miso_pin;
            sck_drv = 1'b1;
            #24 sck_drv = 1'b0;
        end
        #100 ss_n_drv = 1'b1;
        mosi_drv = ~mosi_drv;
    endtask
endmodule

`default_nettype wire

/* File: test/sfl_core_tb.sv */
// self-checking bench for the serial port core against a far-side peer.
// assumes default divisors; pins are resolved here from the enables.
`timescale 1ns/100ps
`default_nettype none
`include "sfl_params.svh"

module sfl_core_tb;
    import sfl_pkg::*;
    logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, fcpol = 0, fcpha = 0, ss_hi = 1;
    logic [7:0] reg_addr = 8'h00;
    sfl_byte_t reg_wdata = 8'h00;
    logic [7:0] reg_rdata, rxb;
    logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq_rx_err, irq_tx;
    logic p_sck, p_mosi, p_miso, p_ss_n;
    wire sck, mosi, miso, ss_n;
    int fails = 0, n_compared = 0;

    // pin resolution; peer clock follows the chosen idle level
    assign sck = sck_oe ? sck_out : (p_sck ^ fcpol);
    assign mosi = mosi_oe ? mosi_out : p_mosi;
    assign miso = miso_oe ? miso_out : p_miso;
    assign ss_n = p_ss_n & ss_hi;

    always #5 clock = ~clock;

    sfl_core i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sck_in(sck),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_n_in(ss_n), .irq_rx_err(irq_rx_err), .irq_tx(irq_tx));
    sfl_peer i_peer (.sck_pin(sck), .mosi_pin(mosi), .miso_pin(miso), .clock_idle_level_sel(fcpol),
        .clock_phase_sel(fcpha), .miso_drv(p_miso), .sck_drv(p_sck), .mosi_drv(p_mosi),
        .ss_n_drv(p_ss_n));

    // ----------------------------------------
    // bus cycles and compare
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock) #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge clock) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock) #1;
        reg_rd = 1'b0;
        chk(reg_rdata & m, e);
    endtask
    task automatic pull_ss();
        ss_hi = 1'b0;
        repeat (8) @(posedge clock);
        #1 ss_hi = 1'b1;
        repeat (6) @(posedge clock);
        #1;
    endtask
    // one master byte; start bound covers one bit time plus the idle half bit
    task automatic m_go(input logic [7:0] tx, input logic [7:0] rx);
        int n;
        i_peer.load(rx);
        wr(`SFL_OFS_DATA, tx);
        for (n = 0; n < 14 && sck === fcpol; n++) @(posedge clock) #1;
        chk({7'h00, n < 14}, 8'h01);
        for (n = 0; n < 100 && i_peer.s_cnt < 8; n++) @(posedge clock) #1;
        repeat (10) @(posedge clock);
        #1 chk(i_peer.s_rx, tx);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rc(`SFL_OFS_CTRL, 8'hff, `SFL_CTRL_RST);
        rc(`SFL_OFS_STAT, 8'hff, `SFL_STAT_RST);
        rc(8'h13, 8'hff, 8'h00);
        wr(`SFL_OFS_CTRL, 8'h49);
        rc(`SFL_OFS_CTRL, 8'hff, 8'h09);
        chk({7'h00, irq_tx}, 8'h01);
        wr(`SFL_OFS_STAT, 8'hff);
        rc(`SFL_OFS_STAT, 8'hff, 8'h4f);
        wr(`SFL_OFS_STAT, 8'h01);
    endtask
    task automatic t_formats();
        for (int f = 0; f < 4; f++) begin
            fcpol = f[1];
            fcpha = f[0];
            wr(`SFL_OFS_CTRL, {3'b101, f[1:0], 3'b000});
            wr(`SFL_OFS_CTRL, {3'b101, f[1:0], 3'b010});
            m_go(8'ha5 ^ f[7:0], 8'h3c + f[7:0]);
            chk({7'h00, irq_rx_err}, 8'h01);
            rc(`SFL_OFS_STAT, 8'hff, 8'h89);
            rc(`SFL_OFS_DATA, 8'hff, 8'h3c + f[7:0]);
            rc(`SFL_OFS_STAT, 8'hff, 8'h09);
        end
    endtask
    task automatic t_overrun();
        fcpol = 1'b0;
        fcpha = 1'b0;
        wr(`SFL_OFS_STAT, 8'h41);
        wr(`SFL_OFS_CTRL, 8'ha0);
        wr(`SFL_OFS_CTRL, 8'ha2);
        m_go(8'h11, 8'h5a);
        m_go(8'h22, 8'hc3);
        rc(`SFL_OFS_STAT, 8'hff, 8'he9);
        rc(`SFL_OFS_DATA, 8'hff, 8'h5a);
        rc(`SFL_OFS_STAT, 8'hff, 8'h49);
    endtask
    task automatic t_mfault();
        wr(`SFL_OFS_STAT, 8'h45);
        wr(`SFL_OFS_CTRL, 8'ha2);
        pull_ss();
        chk({7'h00, irq_rx_err}, 8'h01);
        chk({7'h00, sck_oe}, 8'h00);
        rc(`SFL_OFS_STAT, 8'hff, 8'h5d);
        rc(`SFL_OFS_CTRL, 8'hff, 8'ha0);
        wr(`SFL_OFS_CTRL, 8'h20);
        rc(`SFL_OFS_STAT, 8'hff, 8'h4d);
        chk({7'h00, irq_rx_err}, 8'h00);
        wr(`SFL_OFS_STAT, 8'h41);
        wr(`SFL_OFS_CTRL, 8'h22);
        pull_ss();
        rc(`SFL_OFS_STAT, 8'hff, 8'h49);
    endtask
    task automatic t_slave();
        wr(`SFL_OFS_CTRL, 8'h00);
        wr(`SFL_OFS_STAT, 8'h45);
        wr(`SFL_OFS_CTRL, 8'h82);
        wr(`SFL_OFS_DATA, 8'h3c);
        chk({7'h00, miso_oe}, 8'h00);
        fork
            i_peer.mxfer(8'ha6, rxb);
            begin
                #80;
                chk({7'h00, miso_oe}, 8'h01);
            end
        join
        chk(rxb, 8'h3c);
        // clocks while deselected must not look like a start over the unread byte
        i_peer.idle_clk();
        repeat (6) @(posedge clock);
        rc(`SFL_OFS_STAT, 8'hb0, 8'h80);
        rc(`SFL_OFS_DATA, 8'hff, 8'ha6);
        pull_ss();
        rc(`SFL_OFS_STAT, 8'h10, 8'h10);
        rc(`SFL_OFS_CTRL, 8'hff, 8'h82);
    endtask

    task automatic final_report();
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        t_reset();
        t_formats();
        t_overrun();
        t_mfault();
        t_slave();
        final_report();
    end

    // watchdog, well beyond the several hundred cycles the run needs
    initial begin
        #200000;
        fails++;
        final_report();
    end
endmodule

`default_nettype wire
